// file: design/rps_regs.svh
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

// ==========================================================================
// Array geometry.
`define RPS_ADDR_W      11
`define RPS_DATA_W      2
`define RPS_WORDS       2048

// ==========================================================================
// Clear sequencer.
`define RPS_CLR_CYCLES  4
`define RPS_CLR_W       2
`define RPS_CLR_IDLE    2'h0
`define RPS_CLR_FIRST   2'h1
`define RPS_CLR_LAST    2'h3
`define RPS_CLR_STEP    2'h1

// ==========================================================================
// Scan chain length and bit positions, serial input side at bit 0.
`define RPS_CHAIN_W     21
`define RPS_POS_OUT0    0
`define RPS_POS_DAT0    1
`define RPS_POS_HOLD    2
`define RPS_POS_WRN     3
`define RPS_POS_SELN    4
`define RPS_POS_PURN    5
`define RPS_POS_CLR     6
`define RPS_POS_ADDR    8
`define RPS_POS_DAT1    19
`define RPS_POS_OUT1    20

// Reset image: all active-low controls inactive, counter idle, address zero.
`define RPS_CHAIN_RST   21'h0_003C

`endif

// file: design/rps_pkg.sv
package rps_pkg;

	// Captured input registers, packed so that bit 0 is the serial input end.
	typedef struct packed {
		logic        out1;
		logic        dat1;
		logic [10:0] addr;
		logic [1:0]  clr;
		logic        purge_n;
		logic        select_n;
		logic        write_n;
		logic        hold_n;
		logic        dat0;
		logic        out0;
	} rps_regs_t;

	// Data word of the array.
	typedef logic [1:0] rps_word_t;

endpackage : rps_pkg

// file: design/rps_scan_chain.sv
`timescale 1ns/10ps
`default_nettype none
`include "rps_regs.svh"

// ==========================================================================
// Input register set that doubles as the serial scan chain.
module rps_scan_chain (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              shift_en,
	input  wire logic              ser_in,
	input  wire rps_pkg::rps_regs_t load_val,
	output rps_pkg::rps_regs_t     regs
);

	rps_pkg::rps_regs_t next_regs;

	// Either shift one place toward the serial output or load the new image.
	always_comb begin
		if (shift_en) begin
			next_regs = rps_pkg::rps_regs_t'({regs[`RPS_CHAIN_W-2:0], ser_in});
		end else begin
			next_regs = load_val;
		end
	end

	// Registers only; reset leaves every control inactive.
	always_ff @(posedge clk) begin
		if (rst) begin
			regs <= rps_pkg::rps_regs_t'(`RPS_CHAIN_RST);
		end else begin
			regs <= next_regs;
		end
	end

endmodule : rps_scan_chain

`default_nettype wire

// file: design/rps_mem_array.sv
`timescale 1ns/10ps
`default_nettype none
`include "rps_regs.svh"

// ==========================================================================
// Storage array with one write port, one read port and a quarter clear.
module rps_mem_array #(
	parameter int ADDR_W = `RPS_ADDR_W,
	parameter int DATA_W = `RPS_DATA_W
) (
	input  wire logic              clk,
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              clr_en,
	input  wire logic [1:0]        clr_quarter,
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [DATA_W-1:0] rd_data
);

	localparam int DEPTH   = 1 << ADDR_W;
	localparam int QUARTER = DEPTH / 4;

	logic [DATA_W-1:0] mem [0:DEPTH-1];

	// Reads are combinational from the stored word.
	assign rd_data = mem[rd_addr];

	// One quarter of the words is zeroed per clear cycle, so four cycles clear all.
	always_ff @(posedge clk) begin
		if (clr_en) begin
			for (int i = 0; i < QUARTER; i++) begin
				mem[{clr_quarter, i[ADDR_W-3:0]}] <= '0;
			end
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

endmodule : rps_mem_array

`default_nettype wire

// file: design/rps_sram_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "rps_regs.svh"

// ==========================================================================
// What this block does
// - Every input except the latch enable is captured on the rising clock edge.
// - Captured hold high means no operation, outputs unchanged, no write or clear.
// - Purge low with hold low starts a four cycle clear; outputs go low at once.
// - During the first three of the four clear cycles every input except scan enable is ignored.
// - Data outputs stay low for the whole clear.
// - Select and write both inactive gives a deselected read driving outputs low.
// - Read needs hold low, select low, write high, no scan, purge high, no clear.
// - Select high with write low blocks the write and keeps outputs.
// - Write needs hold, select, write low, no scan, purge high, no clear.
// - Outputs keep their previous values during a write.
// - Clear begins only with hold low, purge low and scan low now and before.
// - Data and serial output latches pass while latch enable high, hold while low.
// - Each scan cycle shifts the chain once, blocks writes and clears, holds outputs.
// - First scan cycle shifts in the serial input bit, outputs unchanged.
// - Scan exit with scanned hold low shifts then runs the scanned instruction.
// - Scan exit with scanned hold high does nothing but loads the scanned output bits.
// - A scanned clear instruction or nonzero clear state resumes on exit, outputs low.
// - Clear sequencer is the purge bit plus a two bit counter wrapping to zero.
// - Chain order: out0, data0, hold, write, select, purge, counter, address, data1, out1.
// - The array holds 2048 words of two bits, indexed by eleven address bits.
// - A clear sets every stored bit to zero.
module rps_sram_core (
	input  wire logic                   REF_CLK,
	input  wire logic                   RST,
	input  wire logic [`RPS_ADDR_W-1:0] WORD_INDEX,
	input  wire logic                   WRITE_BIT0,
	input  wire logic                   WRITE_BIT1,
	input  wire logic                   CYCLE_HOLD_N,
	input  wire logic                   PURGE_N,
	input  wire logic                   SELECT_N,
	input  wire logic                   WRITE_N,
	input  wire logic                   SCAN_ON,
	input  wire logic                   SCAN_SERIAL_IN,
	input  wire logic                   OUTPUT_LATCH_OPEN,
	output logic                        READ_BIT0,
	output logic                        READ_BIT1,
	output logic                        SCAN_SERIAL_OUT
);

	// ======================================================================
	// Declarations.
	rps_pkg::rps_regs_t  regs;          // Captured inputs, also the scan chain.
	rps_pkg::rps_regs_t  load_val;      // Image loaded when not shifting.
	rps_pkg::rps_word_t  rd_word;       // Word at the captured address.
	rps_pkg::rps_word_t  out_word;      // Registered value of the data outputs.
	rps_pkg::rps_word_t  next_out_word;
	rps_pkg::rps_word_t  data_src;      // Value the data output latches pass when open.
	rps_pkg::rps_word_t  lat_word;      // Data output latch contents.
	rps_pkg::rps_word_t  next_lat_word;
	logic                lat_ser;       // Serial output latch contents.
	logic                next_lat_ser;
	logic                scan_cur;      // Scan enable captured at the last edge.
	logic                scan_prev;     // Scan enable captured the edge before.
	logic                next_scan_cur;
	logic                next_scan_prev;
	logic                shift_en;
	logic                active;
	logic                scan_exit;
	logic                execute;
	logic                clr_start;
	logic                clr_busy;
	logic                clearing;
	logic                rd_op;
	logic                wr_op;
	logic                desel_op;
	logic                nop_exit;
	logic                clr_hold;
	logic [1:0]          clr_adv;

	// ======================================================================
	// Scan enable history.

	// Current and prior scan enable, sampled on every edge.
	always_comb begin
		next_scan_cur  = SCAN_ON;
		next_scan_prev = scan_cur;
	end

	// Scan history registers.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			scan_cur  <= 1'b0;
			scan_prev <= 1'b0;
		end else begin
			scan_cur  <= next_scan_cur;
			scan_prev <= next_scan_prev;
		end
	end

	// ======================================================================
	// Operation decode from the captured registers.

	// Nothing is committed while scan is on now or at the coming edge.
	always_comb begin
		active    = !scan_cur && !SCAN_ON;
		scan_exit = scan_prev && !scan_cur;
		clr_busy  = active && (regs.clr != `RPS_CLR_IDLE);
		execute   = active && !regs.hold_n && (regs.clr == `RPS_CLR_IDLE);
		clr_start = execute && !regs.purge_n;
		clearing  = clr_start || clr_busy;
		rd_op     = execute && regs.purge_n && !regs.select_n && regs.write_n;
		wr_op     = execute && regs.purge_n && !regs.select_n && !regs.write_n;
		desel_op  = execute && regs.purge_n && regs.select_n && regs.write_n;
		nop_exit  = active && scan_exit && regs.hold_n &&
			(regs.clr == `RPS_CLR_IDLE);
	end

	// ======================================================================
	// Clear sequencer.

	// Counter steps to one after the start edge and wraps back to zero.
	always_comb begin
		if (clr_start) begin
			clr_adv = `RPS_CLR_FIRST;
		end else if (clr_busy) begin
			clr_adv = 2'(regs.clr + `RPS_CLR_STEP);
		end else begin
			clr_adv = regs.clr;
		end
		// Inputs are frozen on the edges that close clear cycles 0 to 2.
		clr_hold = clr_start || (clr_busy && (regs.clr != `RPS_CLR_LAST));
	end

	// ======================================================================
	// Output value selection.

	// Picks what the data outputs show in this cycle.
	always_comb begin
		if (!active) begin
			data_src = out_word;
		end else if (clearing) begin
			data_src = '0;
		end else if (nop_exit) begin
			data_src = {regs.out1, regs.out0};
		end else if (rd_op) begin
			data_src = rd_word;
		end else if (desel_op) begin
			data_src = '0;
		end else begin
			data_src = out_word;
		end
		next_out_word = data_src;
	end

	// Output word register.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			out_word <= '0;
		end else begin
			out_word <= next_out_word;
		end
	end

	// ======================================================================
	// Input capture and scan chain.

	// Builds the image loaded at the edge when the chain is not shifting.
	always_comb begin
		shift_en = SCAN_ON || scan_cur;
		if (clr_hold) begin
			load_val = regs;
		end else begin
			load_val.addr     = WORD_INDEX;
			load_val.dat0     = WRITE_BIT0;
			load_val.dat1     = WRITE_BIT1;
			load_val.hold_n   = CYCLE_HOLD_N;
			load_val.purge_n  = PURGE_N;
			load_val.select_n = SELECT_N;
			load_val.write_n  = WRITE_N;
			load_val.clr      = regs.clr;
			load_val.out0     = 1'b0;
			load_val.out1     = 1'b0;
		end
		load_val.clr  = clr_adv;
		load_val.out0 = data_src[0];
		load_val.out1 = data_src[1];
	end

	// Chain order is fixed by the packed layout of the register struct.
	rps_scan_chain u_chain (
		.clk      (REF_CLK),
		.rst      (RST),
		.shift_en (shift_en),
		.ser_in   (SCAN_SERIAL_IN),
		.load_val (load_val),
		.regs     (regs)
	);

	// ======================================================================
	// Storage array.

	// Writes and clears take effect at the edge that ends the deciding cycle.
	rps_mem_array #(
		.ADDR_W (`RPS_ADDR_W),
		.DATA_W (`RPS_DATA_W)
	) u_mem (
		.clk         (REF_CLK),
		.wr_en       (wr_op),
		.wr_addr     (regs.addr),
		.wr_data     ({regs.dat1, regs.dat0}),
		.clr_en      (clearing),
		.clr_quarter (regs.clr),
		.rd_addr     (regs.addr),
		.rd_data     (rd_word)
	);

	// ======================================================================
	// Output latches.

	// Latch contents follow the source while open and stay put while closed.
	always_comb begin
		if (OUTPUT_LATCH_OPEN) begin
			next_lat_word = data_src;
			next_lat_ser  = regs.out1;
		end else begin
			next_lat_word = lat_word;
			next_lat_ser  = lat_ser;
		end
	end

	// Latch state registers.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			lat_word <= '0;
			lat_ser  <= 1'b0;
		end else begin
			lat_word <= next_lat_word;
			lat_ser  <= next_lat_ser;
		end
	end

	// Open latches pass straight through; closed ones show the held value.
	assign READ_BIT0       = OUTPUT_LATCH_OPEN ? data_src[0] : lat_word[0];
	assign READ_BIT1       = OUTPUT_LATCH_OPEN ? data_src[1] : lat_word[1];
	assign SCAN_SERIAL_OUT = OUTPUT_LATCH_OPEN ? regs.out1 : lat_ser;

endmodule : rps_sram_core

`default_nettype wire

// file: dv/rps_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Port checker for the registered RAM core.
module rps_chk (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic CYCLE_HOLD_N,
	input wire logic PURGE_N,
	input wire logic SELECT_N,
	input wire logic WRITE_N,
	input wire logic SCAN_ON,
	input wire logic OUTPUT_LATCH_OPEN,
	input wire logic READ_BIT0,
	input wire logic READ_BIT1,
	input wire logic SCAN_SERIAL_OUT
);
	logic       sprev;
	logic [1:0] clr;
	logic [1:0] next_clr;
	logic       norm;

	// An edge takes a normal instruction only with no scan now or before and no clear.
	assign norm = !SCAN_ON && !sprev && (clr == 2'h0);

	// Shadow clear count runs one to three after a clear starts.
	always_comb begin
		next_clr = clr;
		if (clr != 2'h0) begin
			next_clr = clr + 2'h1;
		end else if (norm && !CYCLE_HOLD_N && !PURGE_N) begin
			next_clr = 2'h1;
		end
	end

	// Registers the shadow state.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			sprev <= 1'h0;
			clr   <= 2'h0;
		end else begin
			sprev <= SCAN_ON;
			clr   <= next_clr;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	// A clear start seen with the latch open in the following cycle.
	sequence s_clear_start;
		norm && !CYCLE_HOLD_N && !PURGE_N ##1 OUTPUT_LATCH_OPEN;
	endsequence
	// The word shown stays the same across two open cycles.
	property p_kept(cond);
		cond && OUTPUT_LATCH_OPEN ##1 OUTPUT_LATCH_OPEN |-> $stable({READ_BIT1, READ_BIT0});
	endproperty

	AST_CLEAR_LOW: assert property (s_clear_start |-> {READ_BIT1, READ_BIT0} == 2'h0)
		else $error("Outputs not low as a clear starts.");
	AST_CLEAR_HELD: assert property (clr != 2'h0 && OUTPUT_LATCH_OPEN |-> !READ_BIT0 && !READ_BIT1)
		else $error("Outputs driven during a clear.");
	AST_CLEAR_END: assert property (clr == 2'h3 ##1 OUTPUT_LATCH_OPEN |-> !READ_BIT0 && !READ_BIT1)
		else $error("Outputs driven in the last clear cycle.");
	AST_HOLD_KEEP: assert property (p_kept(norm && CYCLE_HOLD_N))
		else $error("Outputs moved with the cycle held.");
	AST_DESELECT_LOW: assert property (norm && !CYCLE_HOLD_N && PURGE_N && SELECT_N && WRITE_N
		##1 OUTPUT_LATCH_OPEN |-> !READ_BIT0 && !READ_BIT1) else $error("Deselect left outputs high.");
	AST_INHIBIT_KEEP: assert property (p_kept(norm && !CYCLE_HOLD_N && PURGE_N && SELECT_N && !WRITE_N))
		else $error("Outputs moved on an inhibited write.");
	AST_WRITE_KEEP: assert property (p_kept(norm && !CYCLE_HOLD_N && PURGE_N && !SELECT_N && !WRITE_N))
		else $error("Outputs moved on a write.");
	AST_SCAN_KEEP: assert property (p_kept(SCAN_ON))
		else $error("Outputs moved while scanning.");
	AST_SCAN_ENTRY: assert property (p_kept(SCAN_ON && !sprev))
		else $error("Outputs moved on the first shift.");
	AST_LATCH_KEEP: assert property (!OUTPUT_LATCH_OPEN ##1 !OUTPUT_LATCH_OPEN
		|-> $stable({READ_BIT1, READ_BIT0, SCAN_SERIAL_OUT})) else $error("Closed latch changed.");
endmodule : rps_chk

bind rps_sram_core rps_chk chk (.REF_CLK(REF_CLK), .RST(RST), .CYCLE_HOLD_N(CYCLE_HOLD_N),
	.PURGE_N(PURGE_N), .SELECT_N(SELECT_N), .WRITE_N(WRITE_N), .SCAN_ON(SCAN_ON),
	.OUTPUT_LATCH_OPEN(OUTPUT_LATCH_OPEN), .READ_BIT0(READ_BIT0), .READ_BIT1(READ_BIT1),
	.SCAN_SERIAL_OUT(SCAN_SERIAL_OUT));
`default_nettype wire

// file: dv/rps_host.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Host controller model: one instruction per clock, control as {hold, purge, select, write}.
module rps_host (
	input  wire logic   clk,
	output logic [10:0] addr,
	output logic [1:0]  data,
	output logic [3:0]  ctl,
	output logic        scan,
	output logic        ser
);
	// Starts idle so that no stray edge commits anything.
	initial begin
		addr = 11'h000;
		data = 2'h0;
		ctl  = 4'hF;
		scan = 1'h0;
		ser  = 1'h0;
	end

	// Drives one input set just after a rising edge and holds it to the next.
	task cyc(input logic [3:0] c, input logic [10:0] a, input logic [1:0] d,
		input logic s, input logic i);
		@(posedge clk);
		ctl  <= c;
		addr <= a;
		data <= d;
		scan <= s;
		ser  <= i;
	endtask : cyc

	// Normal instructions keep scan low, so each follows a cycle with scan low.
	task rd(input logic [10:0] a); cyc(4'h5, a, 2'h0, 1'h0, 1'h0); endtask : rd
	task wr(input logic [10:0] a, input logic [1:0] d); cyc(4'h4, a, d, 1'h0, 1'h0); endtask : wr
	task pg; cyc(4'h3, 11'h000, 2'h0, 1'h0, 1'h0); endtask : pg
	task nop; cyc(4'hF, 11'h000, 2'h0, 1'h0, 1'h0); endtask : nop
	task des; cyc(4'h7, 11'h000, 2'h0, 1'h0, 1'h0); endtask : des
	task inh(input logic [10:0] a, input logic [1:0] d); cyc(4'h6, a, d, 1'h0, 1'h0); endtask : inh
	task hw(input logic [10:0] a, input logic [1:0] d); cyc(4'hC, a, d, 1'h0, 1'h0); endtask : hw
endmodule : rps_host
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define RPS_CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("ERROR %0t: got %h want %h", $time, g, e); end end
// ==========================================================================
// Self-checking bench for the registered RAM core.
module testbench;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        latch_open = 1'h1;
	int          err_total = 0;
	int          samples_checked = 0;
	wire  [10:0] addr;
	wire  [1:0]  data;
	wire  [3:0]  ctl;
	wire         scan;
	wire         ser;
	wire  [1:0]  q;
	wire         sout;

	// Clock of 5 ns.
	always #2.5 clk = ~clk;

	rps_host host (.clk(clk), .addr(addr), .data(data), .ctl(ctl), .scan(scan), .ser(ser));

	rps_sram_core dut (
		.REF_CLK           (clk),
		.RST               (rst),
		.WORD_INDEX        (addr),
		.WRITE_BIT0        (data[0]),
		.WRITE_BIT1        (data[1]),
		.CYCLE_HOLD_N      (ctl[3]),
		.PURGE_N           (ctl[2]),
		.SELECT_N          (ctl[1]),
		.WRITE_N           (ctl[0]),
		.SCAN_ON           (scan),
		.SCAN_SERIAL_IN    (ser),
		.OUTPUT_LATCH_OPEN (latch_open),
		.READ_BIT0         (q[0]),
		.READ_BIT1         (q[1]),
		.SCAN_SERIAL_OUT   (sout)
	);

	// Prints the counts and the verdict, then ends the run.
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	// Writes, reads, deselect, inhibit and held cycles back to back.
	task t_rw;
		host.wr(11'h7FF, 2'h2);
		host.wr(11'h000, 2'h1);
		host.rd(11'h7FF);
		host.wr(11'h400, 2'h3);
		#1 `RPS_CHK(q, 2'h2)
		host.des();
		#1 `RPS_CHK(q, 2'h2)
		host.inh(11'h000, 2'h3);
		#1 `RPS_CHK(q, 2'h0)
		host.hw(11'h000, 2'h2);
		#1 `RPS_CHK(q, 2'h0)
		host.rd(11'h000);
		#1 `RPS_CHK(q, 2'h0)
		host.nop();
		#1 `RPS_CHK(q, 2'h1)
	endtask : t_rw

	// Clear with writes offered during it, then every quarter reads zero.
	task t_purge;
		for (int i = 0; i < 4; i++) begin
			host.wr({i[1:0], 9'h0AB}, 2'h3);
		end
		host.pg();
		for (int i = 0; i < 3; i++) begin
			host.wr(11'h000, 2'h3);
			#1 `RPS_CHK(q, 2'h0)
		end
		host.rd(11'h000);
		#1 `RPS_CHK(q, 2'h0)
		host.nop();
		#1 `RPS_CHK(q, 2'h0)
		for (int i = 0; i < 4; i++) begin
			host.rd({i[1:0], 9'h0AB});
			host.nop();
			#1 `RPS_CHK(q, 2'h0)
		end
	endtask : t_purge

	// A read behind a closed latch shows only once it opens.
	task t_latch;
		host.wr(11'h000, 2'h2);
		host.des();
		host.nop();
		host.rd(11'h000);
		latch_open <= 1'h0;
		host.nop();
		#1 `RPS_CHK(q, 2'h0)
		@(posedge clk) latch_open <= 1'h1;
		#1 `RPS_CHK(q, 2'h2)
	endtask : t_latch

	// Shifts a chain image in, first bit ending at the far end, then exits scan.
	task shift_in(input rps_pkg::rps_regs_t v, input logic [1:0] held);
		for (int i = 20; i > 0; i--) begin
			host.cyc(4'hF, 11'h000, 2'h0, 1'h1, v[i]);
			#1 `RPS_CHK(q, held)
		end
		host.cyc(4'hF, 11'h000, 2'h0, 1'h0, v[0]);
		#1 `RPS_CHK(q, held)
		host.nop();
	endtask : shift_in

	// Exit with the cycle held loads the scanned output bits.
	task t_scan_nop;
		shift_in('{out1: 1'h0, dat1: 1'h1, addr: 11'h5A5, clr: 2'h0, purge_n: 1'h1,
			select_n: 1'h1, write_n: 1'h1, hold_n: 1'h1, dat0: 1'h0, out0: 1'h1}, 2'h2);
		#1 `RPS_CHK(q, 2'h1)
		`RPS_CHK(sout, 1'h0)
	endtask : t_scan_nop

	// Scanned read runs on exit; a scanned clear state resumes and wraps.
	task t_scan_run;
		shift_in('{out1: 1'h0, dat1: 1'h0, addr: 11'h000, clr: 2'h0, purge_n: 1'h1,
			select_n: 1'h0, write_n: 1'h1, hold_n: 1'h0, dat0: 1'h0, out0: 1'h0}, 2'h1);
		#1 `RPS_CHK(q, 2'h2)
		host.wr(11'h7AB, 2'h3);
		// An idle cycle lets the write land before scan blocks array updates.
		host.nop();
		shift_in('{out1: 1'h1, dat1: 1'h0, addr: 11'h000, clr: 2'h3, purge_n: 1'h1,
			select_n: 1'h1, write_n: 1'h1, hold_n: 1'h1, dat0: 1'h0, out0: 1'h1}, 2'h2);
		#1 `RPS_CHK(q, 2'h0)
		host.rd(11'h7AB);
		host.rd(11'h000);
		#1 `RPS_CHK(q, 2'h0)
		host.nop();
		#1 `RPS_CHK(q, 2'h2)
	endtask : t_scan_run

	// A reset in mid-run returns the outputs low and leaves the core idle.
	task t_reset;
		@(posedge clk) rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		#1 `RPS_CHK(q, 2'h0)
		host.nop();
		host.rd(11'h000);
		host.nop();
		#1 `RPS_CHK(q, 2'h2)
	endtask : t_reset

	// Main sequence after 20 cycles of reset.
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		t_rw;
		t_purge;
		t_latch;
		t_scan_nop;
		t_scan_run;
		t_reset;
		wrap_up;
	end

	// Watchdog well beyond the 130 or so cycles the tests need.
	initial begin
		#20000;
		err_total++;
		wrap_up;
	end
endmodule : testbench
`default_nettype wire
